// ---- rtl/pemb_top.sv ----
// Port pins and multiplexed external memory bus
`timescale 1ns/100ps
`default_nettype none
`include "pemb_cfg.svh"
module pemb_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic external_access_select,
  input wire logic verify_mode,
  input wire logic [7:0] verify_code,
  input wire logic [3:0] latch_wr,
  input wire logic [7:0] latch_wdata,
  input wire logic fetch_req,
  input wire logic [15:0] pc,
  input wire logic xdata_req,
  input wire logic xdata_wr,
  input wire logic xdata_wide,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  input wire logic serial_tx,
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe,
  output logic ale,
  output logic program_store_read_strobe_n,
  output logic core_reset,
  output logic mc_tick,
  output logic fetch_external,
  output logic [7:0] code_byte,
  output logic code_valid,
  output logic [7:0] xdata_rdata,
  output logic xdata_done,
  output logic [31:0] port_pins,
  output logic [15:0] verify_addr,
  output logic timer_two_count_in,
  output logic timer_two_trigger_in,
  output logic serial_rx,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic timer_zero_input,
  output logic timer_one_input
);
  // ==========================================================
  // Pin synchronisers
  logic [33:0] sync1_reg;
  logic [33:0] sync2_reg;
  always_ff @(posedge clk_sys) begin
    sync1_reg <= {reset_pin, external_access_select, p3_in, p2_in, p1_in, p0_in};
    sync2_reg <= sync1_reg;
  end
  logic rst_s, ea_s;
  logic [7:0] p0_s, p1_s, p2_s, p3_s;
  assign {rst_s, ea_s, p3_s, p2_s, p1_s, p0_s} = sync2_reg;

  // ==========================================================
  // Reset pin qualification
  logic [4:0] rst_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !rst_s) begin
      rst_cnt_reg <= '0;
      core_reset <= !rst_n;
    end else if (rst_cnt_reg != 5'(`PEMB_RST_CYC)) begin
      rst_cnt_reg <= rst_cnt_reg + 5'h1;
    end else begin
      core_reset <= 1'b1;
    end
  end

  // ==========================================================
  // Machine cycle phase
  pemb_phase_if ph_if ();
  pemb_phase u_phase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .hold(core_reset),
    .ph_if(ph_if.gen)
  );
  pemb_pkg::pemb_phase_t ph, hp;
  assign ph = ph_if.phase;
  assign hp = (ph >= `PEMB_HALF) ? ph - `PEMB_HALF : ph;

  // ==========================================================
  // Cycle kind selection
  pemb_pkg::pemb_cyc_e cyc_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg, wide_reg, fetch_ext;
  assign fetch_ext = !ea_s || (pc > `PEMB_INT_TOP);
  always_ff @(posedge clk_sys) begin
    if (!rst_n || core_reset) begin
      cyc_reg <= pemb_pkg::PEMB_CYC_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else if (ph == `PEMB_LAST_PH) begin
      wr_reg <= xdata_wr;
      wide_reg <= xdata_wide;
      wdata_reg <= xdata_wdata;
      addr_reg <= xdata_req ? xdata_addr : pc;
      if (xdata_req) begin
        cyc_reg <= pemb_pkg::PEMB_CYC_XDATA;
      end else if (fetch_req && fetch_ext) begin
        cyc_reg <= pemb_pkg::PEMB_CYC_FETCH;
      end else begin
        cyc_reg <= pemb_pkg::PEMB_CYC_IDLE;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    mc_tick <= rst_n && !core_reset && ph == `PEMB_PRE_LAST;
    fetch_external <= rst_n && fetch_ext;
  end

  // ==========================================================
  // Bus strobes and first port
  logic is_f, is_x, stb, lo_addr;
  logic [15:0] cur_addr;
  assign is_f = cyc_reg == pemb_pkg::PEMB_CYC_FETCH;
  assign is_x = cyc_reg == pemb_pkg::PEMB_CYC_XDATA;
  assign stb = is_x && ph >= `PEMB_STB_BEG && ph <= `PEMB_STB_END;
  assign lo_addr = (is_f || (is_x && ph < `PEMB_HALF)) && hp <= `PEMB_ADDR_END;
  assign cur_addr = (is_f && ph >= `PEMB_HALF) ? addr_reg + 16'h1 : addr_reg;
  logic [7:0] latch0_reg, latch1_reg, latch2_reg, latch3_reg;
  logic rd_stb_reg, wr_stb_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ale <= 1'b0;
      program_store_read_strobe_n <= 1'b1;
      rd_stb_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      p0_out <= '0;
      p0_oe <= '0;
    end else begin
      ale <= !core_reset && hp <= `PEMB_ALE_END && !(is_x && ph >= `PEMB_HALF);
      program_store_read_strobe_n <= !(is_f && hp >= `PEMB_PROGRAM_STORE_READ_STROBE_BEG
        && hp <= `PEMB_PROGRAM_STORE_READ_STROBE_END);
      rd_stb_reg <= stb && !wr_reg;
      wr_stb_reg <= stb && wr_reg;
      if (verify_mode) begin
        p0_out <= verify_code;
        p0_oe <= ~verify_code;
      end else if (lo_addr) begin
        p0_out <= cur_addr[7:0];
        p0_oe <= `PEMB_ONES;
      end else if (is_x && wr_reg && ph >= `PEMB_WD_BEG && ph <= `PEMB_WD_END) begin
        p0_out <= wdata_reg;
        p0_oe <= `PEMB_ONES;
      end else if (is_f || is_x) begin
        p0_out <= '0;
        p0_oe <= '0;
      end else begin
        p0_out <= '0;
        p0_oe <= ~latch0_reg;
      end
    end
  end

  // ==========================================================
  // Port latches and ports two to four, preset by the reset pin except the first latch, which only rst_n presets
  logic [7:0] p2_val, p3_val;
  logic p2_addr;
  assign p2_addr = !verify_mode && (is_f || (is_x && wide_reg));
  assign p2_val = p2_addr ? cur_addr[15:8] : latch2_reg;
  // Data strobes leave with the same phases as rd_stb_reg, so write data outlives them
  assign p3_val = latch3_reg
    & {!(stb && !wr_reg), !(stb && wr_reg), 4'hf, serial_tx, 1'b1};
  always_ff @(posedge clk_sys or posedge reset_pin) begin
    if (reset_pin) begin
      latch1_reg <= `PEMB_ONES;
      latch2_reg <= `PEMB_ONES;
      latch3_reg <= `PEMB_ONES;
      p1_out <= `PEMB_ONES;
      p1_oe <= `PEMB_ZERO;
      p2_out <= `PEMB_ONES;
      p2_oe <= `PEMB_ZERO;
      p3_out <= `PEMB_ONES;
      p3_oe <= `PEMB_ZERO;
    end else if (!rst_n) begin
      latch1_reg <= `PEMB_ONES;
      latch2_reg <= `PEMB_ONES;
      latch3_reg <= `PEMB_ONES;
      p1_out <= `PEMB_ONES;
      p1_oe <= `PEMB_ZERO;
      p2_out <= `PEMB_ONES;
      p2_oe <= `PEMB_ZERO;
      p3_out <= `PEMB_ONES;
      p3_oe <= `PEMB_ZERO;
    end else begin
      if (latch_wr[1]) latch1_reg <= latch_wdata;
      if (latch_wr[2]) latch2_reg <= latch_wdata;
      if (latch_wr[3]) latch3_reg <= latch_wdata;
      p1_out <= latch1_reg;
      p1_oe <= verify_mode ? `PEMB_ZERO : ~latch1_reg;
      p2_out <= verify_mode ? `PEMB_ONES : p2_val;
      p2_oe <= verify_mode ? `PEMB_ZERO : (p2_addr ? `PEMB_ONES : ~latch2_reg);
      p3_out <= p3_val;
      p3_oe <= ~p3_val;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latch0_reg <= `PEMB_ONES;
    end else if (latch_wr[0]) begin
      latch0_reg <= latch_wdata;
    end
  end

  // ==========================================================
  // Data capture at the end of each read strobe
  logic program_store_read_strobe_d1_reg, program_store_read_strobe_d2_reg, xs_d1_reg, xs_d2_reg, xrd_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      program_store_read_strobe_d1_reg <= 1'b0;
      program_store_read_strobe_d2_reg <= 1'b0;
      xs_d1_reg <= 1'b0;
      xs_d2_reg <= 1'b0;
      xrd_reg <= 1'b0;
      code_byte <= '0;
      code_valid <= 1'b0;
      xdata_rdata <= '0;
      xdata_done <= 1'b0;
    end else begin
      program_store_read_strobe_d1_reg <= !program_store_read_strobe_n;
      program_store_read_strobe_d2_reg <= program_store_read_strobe_d1_reg;
      xs_d1_reg <= rd_stb_reg || wr_stb_reg;
      xs_d2_reg <= xs_d1_reg;
      if (rd_stb_reg) xrd_reg <= 1'b1;
      else if (wr_stb_reg) xrd_reg <= 1'b0;
      code_valid <= program_store_read_strobe_d2_reg && !program_store_read_strobe_d1_reg;
      if (program_store_read_strobe_d2_reg && !program_store_read_strobe_d1_reg) code_byte <= p0_s;
      xdata_done <= xs_d2_reg && !xs_d1_reg;
      if (xs_d2_reg && !xs_d1_reg && xrd_reg) xdata_rdata <= p0_s;
    end
  end

  // ==========================================================
  // Pin reads and alternate inputs
  always_ff @(posedge clk_sys) begin
    port_pins <= {p3_s, p2_s, p1_s, p0_s};
    verify_addr <= {p2_s, p1_s};
    timer_two_count_in <= p1_s[0];
    timer_two_trigger_in <= p1_s[1];
    serial_rx <= p3_s[0];
    ext_irq_zero <= p3_s[2];
    ext_irq_one <= p3_s[3];
    timer_zero_input <= p3_s[4];
    timer_one_input <= p3_s[5];
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || reset_pin || core_reset || verify_mode);
  sequence s_program_store_read_strobe_low;
    !program_store_read_strobe_n [*3] ##1 program_store_read_strobe_n;
  endsequence
  chk_ale_rate: assert property ($rose(ale) |-> ##6 (ale || $past(is_x)))
    else $error("address strobe period wrong");
  chk_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
    else $error("address strobe width wrong");
  chk_program_store_read_strobe_shape: assert property ($fell(program_store_read_strobe_n) |-> s_program_store_read_strobe_low)
    else $error("program strobe shape wrong");
  chk_program_store_read_strobe_internal: assert property (!program_store_read_strobe_n |-> $past(is_f))
    else $error("program strobe outside fetch");
  chk_p2_addr: assert property ($past(p2_addr) && !$past(latch_wr[2])
    |-> p2_oe == `PEMB_ONES && p2_out == $past(cur_addr[15:8]))
    else $error("high address missing");
  chk_p2_latch: assert property ($past(is_x && !wide_reg) |-> p2_out == $past(latch2_reg))
    else $error("port latch not kept");
  chk_addr_hold: assert property ($fell(ale) && (is_f || is_x) |-> p0_oe == `PEMB_ONES)
    else $error("low address gone before strobe fall");
  chk_fetch_sel: assert property (ph == `PEMB_LAST_PH && !xdata_req && !fetch_ext
    |=> !is_f)
    else $error("external fetch below boundary");
endmodule
`default_nettype wire

// ---- rtl/pemb_cfg.svh ----
// Timing and layout constants of the port and external memory bus
`ifndef PEMB_CFG_SVH
`define PEMB_CFG_SVH
`define PEMB_LAST_PH 4'd11
`define PEMB_PRE_LAST 4'd10
`define PEMB_HALF 4'd6
`define PEMB_ALE_END 4'd1
`define PEMB_ADDR_END 4'd2
`define PEMB_PROGRAM_STORE_READ_STROBE_BEG 4'd3
`define PEMB_PROGRAM_STORE_READ_STROBE_END 4'd5
`define PEMB_STB_BEG 4'd3
`define PEMB_STB_END 4'd8
`define PEMB_WD_BEG 4'd2
`define PEMB_WD_END 4'd9
`define PEMB_INT_TOP 16'h1fff
`define PEMB_RST_MIN_NS 240
`define PEMB_CLK_MHZ 100
`define PEMB_RST_CYC ((`PEMB_RST_MIN_NS * `PEMB_CLK_MHZ + 999) / 1000)
`define PEMB_ONES 8'hff
`define PEMB_ZERO 8'h00
`endif

// ---- rtl/pemb_pkg.sv ----
// Types of the port and external memory bus
package pemb_pkg;
  typedef enum logic [1:0] {PEMB_CYC_IDLE, PEMB_CYC_FETCH, PEMB_CYC_XDATA} pemb_cyc_e;
  typedef logic [3:0] pemb_phase_t;
endpackage

// ---- rtl/pemb_phase_if.sv ----
// Machine cycle phase carrier
`timescale 1ns/100ps
`default_nettype none
interface pemb_phase_if;
  pemb_pkg::pemb_phase_t phase;
  modport gen (output phase);
  modport use_ph (input phase);
endinterface
`default_nettype wire

// ---- rtl/pemb_phase.sv ----
// Machine cycle phase counter, twelve oscillator periods per cycle
`timescale 1ns/100ps
`default_nettype none
`include "pemb_cfg.svh"
module pemb_phase (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hold,
  pemb_phase_if.gen ph_if
);
  // Counter keeps its value for any clock rate, even a stopped clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n || hold) begin
      ph_if.phase <= '0;
    end else if (ph_if.phase == `PEMB_LAST_PH) begin
      ph_if.phase <= '0;
    end else begin
      ph_if.phase <= ph_if.phase + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- test/pemb_mem_model.sv ----
// External program and data memory with address latch
`timescale 1ns/100ps
`default_nettype none
module pemb_mem_model #(
  parameter int DLY = 2
) (
  input wire logic ale,
  input wire logic strobe_n,
  input wire logic [7:0] p0,
  input wire logic [7:0] p2,
  input wire logic [7:0] p3,
  output logic [7:0] data,
  output logic oe
);
  logic [7:0] addr_lo;
  logic [7:0] last_wr;
  logic [15:0] cur;
  function automatic logic [7:0] content(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]};
  endfunction
  // Low address held from the falling strobe
  always @(negedge ale) addr_lo <= p0;
  // Write data taken as the write strobe ends
  always @(posedge p3[6]) last_wr <= p0;
  assign cur = {p2, addr_lo};
  assign #(DLY) oe = ~strobe_n | ~p3[7];
  assign #(DLY) data = content(cur);
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking testbench of the port and external memory bus
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk_sys, rst_n, reset_pin, external_access_select, verify_mode, fetch_req, serial_tx;
  logic xdata_req, xdata_wr, xdata_wide, ale, program_store_read_strobe_n, core_reset, mc_tick;
  logic code_valid, xdata_done, timer_two_count_in, timer_two_trigger_in, serial_rx;
  logic ext_irq_zero, ext_irq_one, timer_zero_input, timer_one_input, mem_oe, fetch_external;
  logic [3:0] latch_wr;
  logic [7:0] verify_code, latch_wdata, xdata_wdata, code_byte, xdata_rdata, mem_data, p0_last;
  logic [7:0] p0_out, p0_oe, p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, ext_p1, ext_p2, ext_p3;
  logic [7:0] seen_p2, seen_rdata;
  logic [15:0] pc, xdata_addr, verify_addr;
  logic [31:0] port_pins;
  logic [7:0] codes[$];
  int fail_count, n_tests, n_ale, n_pstb, n_rd, n_wr;
  wire [7:0] p0_w, p1_w, p2_w, p3_w;
  // ==========================================
  // Pin levels: drivers, pullups, changing float
  assign p0_w = (p0_oe & p0_out) |
    (~p0_oe & (mem_oe ? mem_data : verify_mode ? 8'hff : ~p0_last));
  assign p1_w = (p1_oe & p1_out) | (~p1_oe & ext_p1);
  assign p2_w = (p2_oe & p2_out) | (~p2_oe & ext_p2);
  assign p3_w = (p3_oe & p3_out) | (~p3_oe & ext_p3);
  always @(posedge clk_sys) p0_last <= p0_w;
  pemb_mem_model mem (.ale, .strobe_n(program_store_read_strobe_n), .p0(p0_w), .p2(p2_w),
    .p3(p3_w), .data(mem_data), .oe(mem_oe));
  pemb_top uut (.clk_sys, .rst_n, .reset_pin, .external_access_select, .verify_mode,
    .verify_code, .latch_wr, .latch_wdata, .fetch_req, .pc, .xdata_req, .xdata_wr,
    .xdata_wide, .xdata_addr, .xdata_wdata, .serial_tx, .p0_in(p0_w), .p1_in(p1_w),
    .p2_in(p2_w), .p3_in(p3_w), .p0_out, .p0_oe, .p1_out, .p1_oe, .p2_out, .p2_oe, .p3_out,
    .p3_oe, .ale, .program_store_read_strobe_n, .core_reset, .mc_tick, .fetch_external,
    .code_byte, .code_valid, .xdata_rdata, .xdata_done, .port_pins, .verify_addr,
    .timer_two_count_in, .timer_two_trigger_in, .serial_rx, .ext_irq_zero, .ext_irq_one,
    .timer_zero_input, .timer_one_input);
  // ==========================================
  // Shared tasks
  function automatic logic [7:0] expect_byte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]};
  endfunction
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic write_latch(input int n, input logic [7:0] v);
    latch_wdata = v;
    latch_wr = 4'h1 << n;
    @(posedge clk_sys);
    #1;
    latch_wr = 4'h0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // One machine cycle taken at the tick edge, then watched
  task automatic launch(input logic f, input logic x, input logic w, input logic wd,
                        input logic [15:0] a);
    logic a_prev, s_prev;
    do begin @(posedge clk_sys); #1; end while (mc_tick !== 1'b1);
    {fetch_req, xdata_req, xdata_wr, xdata_wide} = {f, x, w, wd};
    pc = a;
    xdata_addr = a;
    @(posedge clk_sys);
    #1;
    {fetch_req, xdata_req} = 2'b00;
    {n_ale, n_pstb, n_rd, n_wr} = '0;
    codes = {};
    a_prev = ale;
    s_prev = program_store_read_strobe_n;
    for (int i = 1; i <= 15; i++) begin
      @(posedge clk_sys);
      #1;
      if (i <= 12 && ale && !a_prev) n_ale++;
      if (!program_store_read_strobe_n && s_prev) n_pstb++;
      if (!p3_w[7]) n_rd++;
      if (!p3_w[6]) n_wr++;
      if (i == 5) seen_p2 = p2_w;
      if (code_valid) codes.push_back(code_byte);
      if (xdata_done) seen_rdata = xdata_rdata;
      a_prev = ale;
      s_prev = program_store_read_strobe_n;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_fetch();
    external_access_select = 1;
    repeat (3) @(posedge clk_sys);
    launch(1, 0, 0, 0, 16'h0100);
    `CHECK("int strobe", 0, n_pstb)
    `CHECK("int ale", 2, n_ale)
    `CHECK("int select", 1'b0, fetch_external)
    external_access_select = 0;
    repeat (3) @(posedge clk_sys);
    launch(1, 0, 0, 0, 16'h1234);
    `CHECK("ext strobe", 2, n_pstb)
    `CHECK("ext select", 1'b1, fetch_external)
    `CHECK("ext hi addr", 8'h12, seen_p2)
    `CHECK("code count", 2, codes.size())
    for (int k = 0; k < 2; k++) `CHECK("code", expect_byte(16'h1234 + 16'(k)), codes[k])
    external_access_select = 1;
    repeat (3) @(posedge clk_sys);
    launch(1, 0, 0, 0, 16'h2000);
    `CHECK("above top", 2, n_pstb)
    `CHECK("above code", expect_byte(16'h2000), codes[0])
  endtask
  task automatic t_xdata();
    write_latch(2, 8'h5a);
    launch(0, 1, 0, 1, 16'habcd);
    `CHECK("xd ale", 1, n_ale)
    `CHECK("xd strobe", 0, n_pstb)
    `CHECK("xd hi", 8'hab, seen_p2)
    `CHECK("xd rd", 1, n_rd > 0)
    `CHECK("xd rdata", expect_byte(16'habcd), seen_rdata)
    launch(0, 1, 0, 0, 16'habcd);
    `CHECK("narrow hi", 8'h5a, seen_p2)
    `CHECK("narrow rdata", expect_byte(16'h5acd), seen_rdata)
    xdata_wdata = 8'h3c;
    launch(0, 1, 1, 1, 16'h0042);
    `CHECK("wr strobe", 1, n_wr > 0 && n_rd == 0)
    `CHECK("wr data", 8'h3c, mem.last_wr)
    write_latch(2, 8'hff);
  endtask
  task automatic t_ports();
    write_latch(0, 8'h0f);
    `CHECK("p0 oe", 8'hf0, p0_oe)
    `CHECK("p0 low", 8'h00, p0_out & p0_oe)
    write_latch(0, 8'hff);
    write_latch(1, 8'ha5);
    `CHECK("p1 pins", 8'ha5, p1_w)
    write_latch(1, 8'hff);
    ext_p1 = 8'hfc;
    ext_p3 = 8'hc2;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHECK("p1 read", 8'hfc, port_pins[15:8])
    `CHECK("p2 p3 read", 16'hc2ff, port_pins[31:16])
    `CHECK("t2 in", 2'b00, {timer_two_trigger_in, timer_two_count_in})
    `CHECK("p3 alt", 5'h00,
      {timer_one_input, timer_zero_input, ext_irq_one, ext_irq_zero, serial_rx})
    {ext_p1, ext_p3} = 16'hffff;
    serial_tx = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHECK("t2 idle", 2'b11, {timer_two_trigger_in, timer_two_count_in})
    `CHECK("p3 idle", 5'h1f,
      {timer_one_input, timer_zero_input, ext_irq_one, ext_irq_zero, serial_rx})
    `CHECK("tx pin", 1'b0, p3_w[1])
    serial_tx = 1;
  endtask
  task automatic t_reset_pin();
    write_latch(2, 8'h00);
    @(posedge clk_sys);
    #3;
    reset_pin = 1;
    #1;
    `CHECK("async oe", 8'h00, p2_oe)
    `CHECK("async pins", 16'hffff, {p2_w, p1_w})
    repeat (20) @(posedge clk_sys);
    #1;
    `CHECK("early core", 1'b0, core_reset)
    repeat (10) @(posedge clk_sys);
    #1;
    `CHECK("core held", 1'b1, core_reset)
    reset_pin = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHECK("core free", 1'b0, core_reset)
  endtask
  task automatic t_verify();
    verify_mode = 1;
    verify_code = 8'h3c;
    {ext_p2, ext_p1} = 16'h1234;
    repeat (5) @(posedge clk_sys);
    #1;
    `CHECK("code oe", 8'hc3, p0_oe)
    `CHECK("code pins", 8'h3c, p0_w)
    `CHECK("vaddr", 16'h1234, verify_addr)
    verify_mode = 0;
    {ext_p2, ext_p1} = 16'hffff;
  endtask
  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, reset_pin, verify_mode, fetch_req, xdata_req, xdata_wr, xdata_wide} = '0;
    {external_access_select, latch_wr, p0_last} = '0;
    serial_tx = 1;
    {verify_code, latch_wdata, xdata_wdata, pc, xdata_addr} = '0;
    {ext_p1, ext_p2, ext_p3} = '1;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_fetch();
    t_xdata();
    t_ports();
    t_reset_pin();
    t_verify();
    tally_and_finish();
  end
endmodule
`default_nettype wire
